// File: core/adcsz_defs.svh
`ifndef ADCSZ_DEFS_SVH
`define ADCSZ_DEFS_SVH

// clock and timing
`define ADCSZ_CLK_HZ         20000000
`define ADCSZ_CLK_PERIOD_NS  50
`define ADCSZ_RTC_PERIOD_MS  1000
`define ADCSZ_CONV_TIME_NS   3000
`define ADCSZ_RTC_CYCLES     (`ADCSZ_CLK_HZ / 1000 * `ADCSZ_RTC_PERIOD_MS)
`define ADCSZ_CONV_CYCLES    ((`ADCSZ_CONV_TIME_NS + `ADCSZ_CLK_PERIOD_NS - 1) / `ADCSZ_CLK_PERIOD_NS)

// register byte offsets
`define ADCSZ_OFS_MODE0      8'h00
`define ADCSZ_OFS_MODE2      8'h04
`define ADCSZ_OFS_RTCCTL     8'h08
`define ADCSZ_OFS_MASK1H     8'h0C
`define ADCSZ_OFS_RESULT     8'h10
`define ADCSZ_OFS_STATUS     8'h14

// mode register zero fields
`define ADCSZ_M0_STBY_BIT    0
`define ADCSZ_M0_TMODE_LSB   1
`define ADCSZ_M0_TSRC_LSB    3
`define ADCSZ_M0_RES_BIT     5
`define ADCSZ_M0_RESET       8'h00

// field codes
`define ADCSZ_TMODE_HW_WAIT  2'h3
`define ADCSZ_TSRC_RTC       2'h2
`define ADCSZ_RES_TEN        1'h0

// single bit registers, all bit 0
`define ADCSZ_M2_SNZ_BIT     0
`define ADCSZ_RTCCTL_EN_BIT  0
`define ADCSZ_MASK_RTC_BIT   0

// status register bits
`define ADCSZ_ST_DONE_BIT    0
`define ADCSZ_ST_SNZ_BIT     1
`define ADCSZ_ST_BUSY_BIT    2
`define ADCSZ_ST_RTC_BIT     3

`endif

// File: core/adcsz_pkg.sv
package adcsz_pkg;

   // conversion engine states
   typedef enum logic [0:0] {
      ST_IDLE,
      ST_CONV
   } adcsz_state_t;

   typedef logic [15:0] adcsz_result_t;

endpackage : adcsz_pkg

// File: core/adcsz_conv_if.sv
`timescale 1ns/1ps
interface adcsz_conv_if;
   logic                   start;
   logic                   res_eight;
   logic [9:0]             sample;
   logic                   busy;
   logic                   done;
   adcsz_pkg::adcsz_result_t result;

   // controller side
   modport ctl (output start, output res_eight, output sample,
                input busy, input done, input result);
   // engine side
   modport eng (input start, input res_eight, input sample,
                output busy, output done, output result);
endinterface : adcsz_conv_if

// File: core/adcsz_conv.sv
`timescale 1ns/1ps
`include "adcsz_defs.svh"
module adcsz_conv #(
   parameter int CONV_CYCLES = `ADCSZ_CONV_CYCLES
) (
   // clock and reset
   input  wire logic   clk_i,
   input  wire logic   rst_i,
   // controller link
   adcsz_conv_if.eng   cv
);
   localparam int DONE_LAT = CONV_CYCLES + 1;
   localparam int CW       = $clog2(CONV_CYCLES + 1);

   adcsz_pkg::adcsz_state_t  state_q;
   logic [CW-1:0]            cnt_q;
   logic [9:0]               hold_q;
   logic                     done_q;
   adcsz_pkg::adcsz_result_t result_q;
   wire  adcsz_pkg::adcsz_result_t res_ten;
   wire  adcsz_pkg::adcsz_result_t res_eight;
   wire  adcsz_pkg::adcsz_result_t shaped;

   // left aligned result, low bits zero
   assign res_ten   = {hold_q, 6'h00};
   assign res_eight = {hold_q[9:2], 8'h00};
   assign shaped    = cv.res_eight ? res_eight : res_ten;
   assign cv.busy   = (state_q == adcsz_pkg::ST_CONV);
   assign cv.done   = done_q;
   assign cv.result = result_q;

   // one-shot conversion sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q  <= adcsz_pkg::ST_IDLE;
         cnt_q    <= '0;
         hold_q   <= 10'h000;
         done_q   <= 1'b0;
         result_q <= 16'h0000;
      end else begin
         done_q <= 1'b0;
         case (state_q)
            adcsz_pkg::ST_IDLE: begin
               if (cv.start) begin
                  state_q <= adcsz_pkg::ST_CONV;
                  cnt_q   <= CW'(CONV_CYCLES - 1);
                  hold_q  <= cv.sample;
               end
            end
            adcsz_pkg::ST_CONV: begin
               if (cnt_q == '0) begin
                  result_q <= shaped;
                  done_q   <= 1'b1;
                  state_q  <= adcsz_pkg::ST_IDLE;
               end else begin
                  cnt_q <= cnt_q - CW'(1);
               end
            end
            default: state_q <= adcsz_pkg::ST_IDLE;
         endcase
      end
   end

   AST_CONV_LATENCY: assert property (@(posedge clk_i) disable iff (rst_i)
      cv.start && !cv.busy |-> ##DONE_LAT done_q)
      else $error("conversion did not finish in time");
   AST_ONE_SHOT: assert property (@(posedge clk_i) disable iff (rst_i)
      done_q |-> !cv.busy ##1 (!cv.busy || $past(cv.start)))
      else $error("converter repeated without a trigger");
   AST_LEFT_ALIGN: assert property (@(posedge clk_i) disable iff (rst_i)
      done_q |-> result_q[5:0] == 6'h00 && result_q[15:6] == $past(hold_q)
                 || cv.res_eight)
      else $error("result not left aligned");
endmodule : adcsz_conv

// File: core/adcsz_top.sv
`timescale 1ns/1ps
`include "adcsz_defs.svh"
module adcsz_top #(
   parameter int RTC_PERIOD_CYCLES = `ADCSZ_RTC_CYCLES,
   parameter int CONV_CYCLES       = `ADCSZ_CONV_CYCLES
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // analog front end and power state
   input  wire logic [9:0]  analog_input_zero_i,
   input  wire logic        cpu_stop_i,
   // event outputs
   output logic             conversion_done_irq_o,
   output logic             rtc_irq_o,
   output logic             snooze_active_o
);
   localparam int RW = $clog2(RTC_PERIOD_CYCLES + 1);
   localparam logic [RW-1:0] RTC_MAX = RW'(RTC_PERIOD_CYCLES - 1);

   // control registers
   logic          standby_q;
   logic [1:0]    trig_mode_q;
   logic [1:0]    trig_src_q;
   logic          res_sel_q;
   logic          snooze_en_q;
   logic          rtc_en_q;
   logic          rtc_mask_q;
   // state
   logic          done_flag_q;
   logic          rtc_flag_q;
   logic          snooze_q;
   logic [RW-1:0] rtc_cnt_q;
   logic          rtc_tick_q;
   logic          ack_q;
   logic [31:0]   dat_q;
   logic          done_irq_q;
   logic          rtc_irq_q;

   adcsz_conv_if cv ();

   // bus decode
   wire        wb_req    = wb_cyc_i && wb_stb_i && !ack_q;
   wire        wr_lo     = wb_req && wb_we_i && wb_sel_i[0];
   wire        wr_mode0  = wr_lo && (wb_adr_i == `ADCSZ_OFS_MODE0);
   wire        wr_mode2  = wr_lo && (wb_adr_i == `ADCSZ_OFS_MODE2);
   wire        wr_rtcctl = wr_lo && (wb_adr_i == `ADCSZ_OFS_RTCCTL);
   wire        wr_mask   = wr_lo && (wb_adr_i == `ADCSZ_OFS_MASK1H);
   wire        wr_status = wr_lo && (wb_adr_i == `ADCSZ_OFS_STATUS);
   wire        rd_req    = wb_req && !wb_we_i;

   // trigger qualification
   wire        hw_wait   = (trig_mode_q == `ADCSZ_TMODE_HW_WAIT);
   wire        src_rtc   = (trig_src_q == `ADCSZ_TSRC_RTC);
   wire        armed     = standby_q && hw_wait && src_rtc && snooze_en_q;
   wire        start     = rtc_tick_q && armed && !cv.busy;
   wire        conv_done = cv.done;
   wire        rtc_wrap  = rtc_en_q && (rtc_cnt_q == RTC_MAX);

   // engine link, fixed channel zero
   assign cv.start     = start;
   assign cv.sample    = analog_input_zero_i;
   assign cv.res_eight = (res_sel_q != `ADCSZ_RES_TEN);

   // register read data
   wire [31:0] rd_mode0  = {26'h000_0000, res_sel_q, trig_src_q, trig_mode_q, standby_q};
   wire [31:0] rd_mode2  = {31'h0000_0000, snooze_en_q};
   wire [31:0] rd_rtcctl = {31'h0000_0000, rtc_en_q};
   wire [31:0] rd_mask   = {31'h0000_0000, rtc_mask_q};
   wire [31:0] rd_result = {16'h0000, cv.result};
   wire [31:0] rd_status = {28'h000_0000, rtc_flag_q, cv.busy, snooze_q, done_flag_q};
   wire [31:0] rd_data   =
      (wb_adr_i == `ADCSZ_OFS_MODE0)  ? rd_mode0  :
      (wb_adr_i == `ADCSZ_OFS_MODE2)  ? rd_mode2  :
      (wb_adr_i == `ADCSZ_OFS_RTCCTL) ? rd_rtcctl :
      (wb_adr_i == `ADCSZ_OFS_MASK1H) ? rd_mask   :
      (wb_adr_i == `ADCSZ_OFS_RESULT) ? rd_result :
      (wb_adr_i == `ADCSZ_OFS_STATUS) ? rd_status : 32'h0000_0000;

   // conversion engine
   adcsz_conv #(
      .CONV_CYCLES (CONV_CYCLES)
   ) u_conv (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .cv    (cv)
   );

   // bus acknowledge and read data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else begin
         ack_q <= wb_req;
         if (rd_req) begin
            dat_q <= rd_data;
         end
      end
   end

   // mode register zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         standby_q   <= 1'(`ADCSZ_M0_RESET >> `ADCSZ_M0_STBY_BIT);
         trig_mode_q <= 2'h0;
         trig_src_q  <= 2'h0;
         res_sel_q   <= 1'b0;
      end else if (wr_mode0) begin
         standby_q   <= wb_dat_i[`ADCSZ_M0_STBY_BIT];
         trig_mode_q <= wb_dat_i[`ADCSZ_M0_TMODE_LSB +: 2];
         trig_src_q  <= wb_dat_i[`ADCSZ_M0_TSRC_LSB +: 2];
         res_sel_q   <= wb_dat_i[`ADCSZ_M0_RES_BIT];
      end
   end

   // snooze enable, cleared by done in snooze
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         snooze_en_q <= 1'b0;
      end else if (conv_done && snooze_q) begin
         snooze_en_q <= 1'b0;
      end else if (wr_mode2) begin
         snooze_en_q <= wb_dat_i[`ADCSZ_M2_SNZ_BIT];
      end
   end

   // clock control and mask
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rtc_en_q   <= 1'b0;
         rtc_mask_q <= 1'b0;
      end else begin
         if (wr_rtcctl) begin
            rtc_en_q <= wb_dat_i[`ADCSZ_RTCCTL_EN_BIT];
         end
         if (wr_mask) begin
            rtc_mask_q <= wb_dat_i[`ADCSZ_MASK_RTC_BIT];
         end
      end
   end

   // constant-period counter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rtc_cnt_q  <= '0;
         rtc_tick_q <= 1'b0;
      end else begin
         rtc_tick_q <= rtc_wrap;
         if (!rtc_en_q || rtc_wrap) begin
            rtc_cnt_q <= '0;
         end else begin
            rtc_cnt_q <= rtc_cnt_q + RW'(1);
         end
      end
   end

   // snooze state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         snooze_q <= 1'b0;
      end else if (conv_done) begin
         snooze_q <= 1'b0;
      end else if (start && cpu_stop_i) begin
         snooze_q <= 1'b1;
      end
   end

   // sticky status flags, set beats clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_flag_q <= 1'b0;
         rtc_flag_q  <= 1'b0;
      end else begin
         if (conv_done) begin
            done_flag_q <= 1'b1;
         end else if (wr_status && wb_dat_i[`ADCSZ_ST_DONE_BIT]) begin
            done_flag_q <= 1'b0;
         end
         if (rtc_tick_q) begin
            rtc_flag_q <= 1'b1;
         end else if (wr_status && wb_dat_i[`ADCSZ_ST_RTC_BIT]) begin
            rtc_flag_q <= 1'b0;
         end
      end
   end

   // event pulses
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_irq_q <= 1'b0;
         rtc_irq_q  <= 1'b0;
      end else begin
         done_irq_q <= conv_done;
         rtc_irq_q  <= rtc_tick_q && !rtc_mask_q;
      end
   end

   // outputs straight from flops
   assign wb_ack_o              = ack_q;
   assign wb_dat_o              = dat_q;
   assign conversion_done_irq_o = done_irq_q;
   assign rtc_irq_o             = rtc_irq_q;
   assign snooze_active_o       = snooze_q;

   AST_UNARMED_NO_CONV: assert property (@(posedge clk_i) disable iff (rst_i)
      rtc_tick_q && !armed && !cv.busy |=> !cv.busy ##1 !done_irq_q)
      else $error("unarmed trigger started a conversion");

   AST_SNOOZE_ENTRY: assert property (@(posedge clk_i) disable iff (rst_i)
      start && cpu_stop_i |=> snooze_active_o && cv.busy)
      else $error("stop-state trigger did not enter snooze");

   AST_SNOOZE_EXIT: assert property (@(posedge clk_i) disable iff (rst_i)
      conv_done && snooze_q |=> !snooze_active_o && !snooze_en_q && conversion_done_irq_o)
      else $error("done in snooze did not leave snooze");

   AST_DONE_AFTER_RESULT: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(conversion_done_irq_o) |-> $past(conv_done) && done_flag_q)
      else $error("done interrupt without finished result");

   AST_RTC_PERIOD: assert property (@(posedge clk_i) disable iff (rst_i)
      rtc_tick_q |-> $past(rtc_cnt_q) == RTC_MAX && $past(rtc_en_q))
      else $error("clock event off period");

   AST_RTC_MASK: assert property (@(posedge clk_i) disable iff (rst_i)
      rtc_tick_q |=> rtc_irq_o == !$past(rtc_mask_q))
      else $error("clock interrupt mask not honoured");

   AST_RTC_STOPPED: assert property (@(posedge clk_i) disable iff (rst_i)
      !rtc_en_q [*2] |-> !rtc_tick_q && rtc_cnt_q == '0)
      else $error("clock counter ran while disabled");

   AST_START_CAUSE: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(cv.busy) |-> $past(standby_q && hw_wait && src_rtc && rtc_tick_q))
      else $error("conversion started without armed trigger");

   AST_WB_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus acknowledge not a single cycle");

   // register writes land at the taking edge
   AST_STANDBY_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_mode0 |=> standby_q == $past(wb_dat_i[`ADCSZ_M0_STBY_BIT]))
      else $error("standby bit not written");

   AST_TMODE_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_mode0 |=> trig_mode_q == $past(wb_dat_i[`ADCSZ_M0_TMODE_LSB +: 2]))
      else $error("trigger mode field not written");

   AST_TSRC_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_mode0 |=> trig_src_q == $past(wb_dat_i[`ADCSZ_M0_TSRC_LSB +: 2]))
      else $error("trigger source field not written");

   AST_RES_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_mode0 |=> res_sel_q == $past(wb_dat_i[`ADCSZ_M0_RES_BIT]))
      else $error("resolution bit not written");

   AST_RTC_EN_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_rtcctl |=> rtc_en_q == $past(wb_dat_i[`ADCSZ_RTCCTL_EN_BIT]))
      else $error("count enable bit not written");

   AST_MASK_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_mask |=> rtc_mask_q == $past(wb_dat_i[`ADCSZ_MASK_RTC_BIT]))
      else $error("clock irq mask bit not written");

   AST_SNOOZE_ARM: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_mode2 && !(conv_done && snooze_q) |=> snooze_en_q == $past(wb_dat_i[`ADCSZ_M2_SNZ_BIT]))
      else $error("snooze enable bit not written");

   // snooze only around a stop-state conversion; a masked clock event still starts one
   AST_SNOOZE_CAUSE: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(snooze_active_o) |-> $past(start && cpu_stop_i))
      else $error("snooze entered without stop-state trigger");

   AST_SNOOZE_BUSY: assert property (@(posedge clk_i) disable iff (rst_i)
      snooze_active_o |-> cv.busy || conv_done)
      else $error("snooze held with no conversion");

   AST_MASKED_TRIGGER: assert property (@(posedge clk_i) disable iff (rst_i)
      rtc_tick_q && rtc_mask_q && armed && !cv.busy |=> cv.busy && !rtc_irq_o)
      else $error("masked clock event did not trigger alone");

   // events and flags
   AST_DONE_IRQ_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
      conversion_done_irq_o |=> !conversion_done_irq_o)
      else $error("done interrupt longer than one cycle");

   AST_DONE_FLAG_SET: assert property (@(posedge clk_i) disable iff (rst_i)
      conv_done |=> done_flag_q)
      else $error("done flag not set");

   AST_RTC_IRQ_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
      rtc_irq_o |=> !rtc_irq_o)
      else $error("clock interrupt longer than one cycle");

   AST_TICK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
      rtc_tick_q |=> !rtc_tick_q)
      else $error("clock event longer than one cycle");

   AST_RTC_FLAG_SET: assert property (@(posedge clk_i) disable iff (rst_i)
      rtc_tick_q |=> rtc_flag_q)
      else $error("clock event flag not set");

   // bus read side
   AST_READ_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      !rd_req |=> $stable(wb_dat_o))
      else $error("read data changed without a read");

   AST_UNMAPPED_READ: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_req && wb_adr_i > `ADCSZ_OFS_STATUS |=> wb_dat_o == 32'h0000_0000)
      else $error("unmapped read not zero");
endmodule : adcsz_top

// File: dv/adcsz_src_model.sv
`timescale 1ns/1ps
// behavioural level source driving analog channel zero
module adcsz_src_model (
   // digitised level seen by the converter
   output logic [9:0] level_o
);
   // steady level from time zero, no unknown phase
   initial begin
      level_o = 10'h000;
   end

   // level moves only between conversions, as a slow source would
   task automatic set_level(input logic [9:0] v);
      level_o <= v;
   endtask : set_level
endmodule : adcsz_src_model

// File: dv/test_adc_snooze_trigger_control.sv
`timescale 1ns/1ps
module test_adc_snooze_trigger_control;
   localparam int RTC_P = 200;
   localparam int CONV  = 20;
   typedef struct {logic [7:0] adr; logic [31:0] wd; logic [31:0] exp;} adcsz_row_t;

   logic        clk_i;
   logic        rst_i;
   logic        wb_cyc;
   logic        wb_stb;
   logic        wb_we;
   logic [7:0]  wb_adr;
   logic [3:0]  wb_sel;
   logic [31:0] wb_wdat;
   logic [31:0] wb_rdat;
   logic        wb_ack;
   logic [9:0]  level;
   logic        cpu_stop;
   logic        done_irq;
   logic        rtc_irq;
   logic        snz;
   logic [31:0] rd;
   int          n_errors, tests_run, n_done, n_rtc, n_snz, cyc_n, last_rtc, rtc_gap, k;

   // register table rows: write, read back, expect
   adcsz_row_t rows [6] = '{
      '{8'h00, 32'h0000_003F, 32'h0000_003F}, '{8'h04, 32'h0000_0001, 32'h0000_0001},
      '{8'h08, 32'h0000_0000, 32'h0000_0000}, '{8'h0C, 32'h0000_0001, 32'h0000_0001},
      '{8'h10, 32'hFFFF_FFFF, 32'h0000_0000}, '{8'h20, 32'hFFFF_FFFF, 32'h0000_0000}};
   // unarmed setups: standby off, wrong source, wrong mode, snooze off
   logic [31:0] neg_m0 [4] = '{32'h0000_0016, 32'h0000_000F, 32'h0000_0013, 32'h0000_0017};
   logic [31:0] neg_m2 [4] = '{32'h0000_0001, 32'h0000_0001, 32'h0000_0001, 32'h0000_0000};

   adcsz_src_model src (
      .level_o (level)
   );

   adcsz_top #(.RTC_PERIOD_CYCLES(RTC_P), .CONV_CYCLES(CONV)) uut (
      .clk_i                 (clk_i),
      .rst_i                 (rst_i),
      .wb_cyc_i              (wb_cyc),
      .wb_stb_i              (wb_stb),
      .wb_we_i               (wb_we),
      .wb_adr_i              (wb_adr),
      .wb_sel_i              (wb_sel),
      .wb_dat_i              (wb_wdat),
      .wb_dat_o              (wb_rdat),
      .wb_ack_o              (wb_ack),
      .analog_input_zero_i   (level),
      .cpu_stop_i            (cpu_stop),
      .conversion_done_irq_o (done_irq),
      .rtc_irq_o             (rtc_irq),
      .snooze_active_o       (snz)
   );

   // 20 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   // event counters and clock event spacing
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (done_irq === 1'b1) n_done <= n_done + 1;
      if (snz === 1'b1) n_snz <= n_snz + 1;
      if (rtc_irq === 1'b1) begin
         n_rtc    <= n_rtc + 1;
         rtc_gap  <= cyc_n - last_rtc;
         last_rtc <= cyc_n;
      end
   end

   task automatic report_and_stop;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // one classic bus cycle, held until ack is sampled high
   task automatic wb_rw(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
      int i;
      @(posedge clk_i);
      wb_cyc  <= 1'b1;
      wb_stb  <= 1'b1;
      wb_we   <= w;
      wb_adr  <= a;
      wb_wdat <= d;
      wb_sel  <= 4'hF;
      i = 0;
      do begin
         @(posedge clk_i);
         i++;
      end while (wb_ack !== 1'b1 && i < 20);
      q = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      if (i >= 20) begin
         n_errors++;
         report_and_stop;
      end
   endtask : wb_rw

   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
   endtask : idle

   // bounded wait for the next conversion-done pulse
   task automatic wait_done(input int lim);
      int i;
      int s;
      s = n_done;
      i = 0;
      while (n_done == s && i < lim) begin
         @(posedge clk_i);
         i++;
      end
      if (n_done == s) begin
         n_errors++;
         $display("CHECK FAILED done_wait expected pulse seen none");
         report_and_stop;
      end
   endtask : wait_done

   // main sequence
   initial begin
      rst_i = 1'b1; wb_cyc = 1'b0; wb_stb = 1'b0; wb_we = 1'b0; wb_adr = 8'h00;
      wb_sel = 4'h0; wb_wdat = 32'h0000_0000; cpu_stop = 1'b0;
      n_errors = 0; tests_run = 0; n_done = 0; n_rtc = 0; n_snz = 0;
      cyc_n = 0; last_rtc = 0; rtc_gap = 0;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      check("outs_reset", {29'h0, done_irq, rtc_irq, snz}, 32'h0000_0000);
      for (int i = 0; i < 6; i++) begin
         wb_rw(1'b0, 8'(i * 4), 32'h0000_0000, rd);
         check("reset_reg", rd, 32'h0000_0000);
      end
      foreach (rows[i]) begin
         wb_rw(1'b1, rows[i].adr, rows[i].wd, rd);
         wb_rw(1'b0, rows[i].adr, 32'h0000_0000, rd);
         check("reg_rw", rd, rows[i].exp);
      end
      // counter off: no clock events even unmasked
      wb_rw(1'b1, 8'h0C, 32'h0000_0000, rd);
      idle(450);
      check("rtc_off", n_rtc, 32'h0000_0000);
      wb_rw(1'b1, 8'h08, 32'h0000_0001, rd);
      cpu_stop <= 1'b1;
      // unarmed setups start nothing
      for (int i = 0; i < 4; i++) begin
         wb_rw(1'b1, 8'h04, neg_m2[i], rd);
         wb_rw(1'b1, 8'h00, neg_m0[i], rd);
         idle(450);
         check("no_conv", n_done, 32'h0000_0000);
      end
      check("rtc_gap", rtc_gap, RTC_P);
      check("rtc_unmasked", 32'(n_rtc > 0), 32'h0000_0001);
      // armed snooze conversion with clock irq masked
      wb_rw(1'b1, 8'h0C, 32'h0000_0001, rd);
      src.set_level(10'h2A5);
      wb_rw(1'b1, 8'h00, 32'h0000_0017, rd);
      wb_rw(1'b1, 8'h04, 32'h0000_0001, rd);
      k = n_rtc;
      wait_done(2 * RTC_P + CONV + 10);
      check("snooze_len", n_snz, CONV + 1);
      check("rtc_masked", n_rtc, k);
      wb_rw(1'b0, 8'h10, 32'h0000_0000, rd);
      check("result", rd, {16'h0000, 10'h2A5, 6'h00});
      check("result_shift", rd >> 6, 32'h0000_02A5);
      wb_rw(1'b0, 8'h14, 32'h0000_0000, rd);
      check("done_flag", rd & 32'h0000_0001, 32'h0000_0001);
      check("rtc_flag", rd & 32'h0000_0008, 32'h0000_0008);
      wb_rw(1'b1, 8'h14, 32'h0000_0001, rd);
      wb_rw(1'b0, 8'h14, 32'h0000_0000, rd);
      check("done_flag_clr", rd & 32'h0000_0001, 32'h0000_0000);
      wb_rw(1'b0, 8'h04, 32'h0000_0000, rd);
      check("snooze_clr", rd, 32'h0000_0000);
      idle(450);
      check("one_shot", n_done, 32'h0000_0001);
      // re-arm unmasked: clock event drives the next conversion
      wb_rw(1'b1, 8'h0C, 32'h0000_0000, rd);
      src.set_level(10'h3FF);
      k = n_rtc;
      wb_rw(1'b1, 8'h04, 32'h0000_0001, rd);
      wait_done(2 * RTC_P + CONV + 10);
      check("rtc_with_conv", 32'(n_rtc > k), 32'h0000_0001);
      wb_rw(1'b0, 8'h10, 32'h0000_0000, rd);
      check("result2", rd, 32'h0000_FFC0);
      // eight-bit run while awake: no snooze, enable kept
      cpu_stop <= 1'b0;
      src.set_level(10'h1B7);
      k = n_snz;
      wb_rw(1'b1, 8'h00, 32'h0000_0037, rd);
      wb_rw(1'b1, 8'h04, 32'h0000_0001, rd);
      wait_done(2 * RTC_P + CONV + 10);
      check("awake_no_snooze", n_snz, k);
      wb_rw(1'b0, 8'h10, 32'h0000_0000, rd);
      check("result8", rd, 32'h0000_6D00);
      wb_rw(1'b0, 8'h04, 32'h0000_0000, rd);
      check("snooze_kept", rd, 32'h0000_0001);
      report_and_stop;
   end
endmodule : test_adc_snooze_trigger_control
